// File: pkg/aodi_pkg.sv
/*
  Shared types and constants of the analog output DAC interface: register
  offsets, the control and status layouts, reset values and state carriers.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package aodi_pkg;

  // ----------------------------------------------------------------------
  // Widths, offsets and bus answers
  // ----------------------------------------------------------------------
  localparam int         CH_W         = 4;
  localparam int         PW_W         = 4;
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // Flag inputs default to active low; refill request defaults active high.
  localparam logic [31:0] CONTROL_RESET = 32'h0000_7000;

  typedef enum logic [1:0] {
    REFILL_ON_EMPTY,
    REFILL_ON_HALF_OR_LESS,
    REFILL_ON_NOT_FULL,
    REFILL_HALF_UNTIL_FULL
  } aodi_refill_e;

  // ----------------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]   reserved_hi;
    logic [3:0]   pulse_width;
    logic [3:0]   channels_m1;
    logic         reserved_lo;
    logic [2:0]   flag_pol;
    logic         tc_out_en;
    logic         refill_pol;
    logic         refill_en;
    aodi_refill_e refill_condition_select;
    logic         retransmit_enable_bit;
    logic [1:0]   load_src_secondary;
    logic [1:0]   load_immediate;
    logic         dual_dac;
    logic         multichannel_select;
  } aodi_ctrl_s;

  typedef struct packed {
    logic [19:0] reserved_hi;
    logic [3:0]  chan_select;
    logic [1:0]  reserved_lo;
    logic        data_request;
    logic        host_busy;
    logic        timed_busy;
    logic [2:0]  flags;
  } aodi_status_s;

  // ----------------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } aodi_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } aodi_axil_rsp_s;

  // ----------------------------------------------------------------------
  // State of the interface core
  // ----------------------------------------------------------------------
  typedef struct packed {
    aodi_ctrl_s        ctrl;
    logic [CH_W-1:0]   chan;
    logic [CH_W-1:0]   sel;
    logic [CH_W:0]     burst;
    logic              data_req;
    logic              hyst;
    logic              refill;
    logic              irq;
    logic              retx_n;
    logic              served;
    logic              tc_out;
    logic              aw_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_hold;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } aodi_core_s;

endpackage

// File: logic/aodi_flag_in.sv
/*
  One FIFO flag input: applies the selected polarity, registers the asserted
  level and marks the cycle in which the flag becomes asserted.
  Assumes the raw flag is synchronous to clk.
*/
`timescale 1ns/10ps
module aodi_flag_in (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Flag
  input  wire logic raw,
  input  wire logic active_low,
  output logic      asserted,
  output logic      rise
);
  import aodi_pkg::*;

  typedef struct packed {
    logic level;
    logic rise;
  } aodi_flag_s;

  aodi_flag_s r;
  aodi_flag_s next_r;

  always_comb begin
    next_r       = r;
    next_r.level = raw ^ active_low;
    next_r.rise  = next_r.level & ~r.level;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign asserted = r.level;
  assign rise     = r.rise;
endmodule

// File: logic/aodi_pulse.sv
/*
  Write pulse timed on the output timebase: a start taken on a tick opens
  the pulse, which then lasts width+1 further ticks and ends with done.
  Assumes tick is a one-cycle enable synchronous to clk.
*/
`timescale 1ns/10ps
module aodi_pulse #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Timing
  input  wire logic         tick,
  input  wire logic         start,
  input  wire logic [W-1:0] width,
  // Pulse
  output logic              active,
  output logic              done
);
  import aodi_pkg::*;

  initial begin
    if (W < 1 || W > 16) begin
      $error("aodi_pulse: W out of range");
    end
  end

  typedef struct packed {
    logic         active;
    logic         done;
    logic [W-1:0] count;
  } aodi_pulse_s;

  aodi_pulse_s r;
  aodi_pulse_s next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (start && !r.active) begin
      next_r.active = 1'b1;
      next_r.count  = width;
    end else if (r.active && tick) begin
      if (r.count == '0) begin
        next_r.active = 1'b0;
        next_r.done   = 1'b1;
      end else begin
        next_r.count = r.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign active = r.active;
  assign done   = r.done;
endmodule

// File: logic/aodi_core.sv
/*
  Analog output DAC interface: channel select, timed and host DAC writes,
  write and load strobes, FIFO flag handling, refill and retransmit, and an
  AXI4-Lite register slave. Assumes all pin inputs synchronous to clk and
  output_timebase a one-cycle tick.
*/
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module aodi_core #(
  parameter int CHW = 4,
  parameter int PWW = 4
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Register bus
  input  wire aodi_pkg::aodi_axil_req_s axil_req,
  output aodi_pkg::aodi_axil_rsp_s      axil_rsp,
  // Timing inputs
  input  wire logic                     output_timebase,
  input  wire logic                     update_event,
  input  wire logic                     primary_update,
  input  wire logic                     secondary_update,
  input  wire logic                     buffer_count_terminal_in,
  // FIFO flags and controls
  input  wire logic                     fifo_empty_flag,
  input  wire logic                     fifo_half_full_flag,
  input  wire logic                     fifo_full_flag,
  output logic                          fifo_retransmit_n,
  output logic                          fifo_refill_request,
  output logic                          fifo_interrupt,
  output logic                          timed_data_request,
  output logic                          buffer_count_terminal,
  // Host access
  input  wire logic                     host_dac_request_n,
  input  wire logic [3:0]               host_address,
  output logic                          host_channel_ready,
  output logic                          host_dac_write_n,
  // DAC pins
  output logic [3:0]                    dac_channel_select,
  output logic                          timed_dac_write_n,
  output logic [1:0]                    dac_write_strobe_n,
  output logic [1:0]                    dac_load_strobe_n
);
  import aodi_pkg::*;

  initial begin
    if (CHW != CH_W || PWW != PW_W) begin
      $error("aodi_core: widths must match the register layout");
    end
  end

  aodi_core_s r;
  aodi_core_s next_r;
  logic       empty_as;
  logic       half_as;
  logic       full_as;
  logic       empty_rise;
  logic       timed_act;
  logic       timed_done;
  logic       host_act;
  logic       host_done;
  logic       host_req;
  logic       timed_start;
  logic       host_start;
  logic       wr_any;
  logic       cond;
  logic [CHW:0] burst_len;
  aodi_status_s status;

  // ----------------------------------------------------------------------
  // Flag inputs and pulse generators
  // ----------------------------------------------------------------------
  aodi_flag_in u_empty (
    .clk        (clk),
    .reset      (reset),
    .raw        (fifo_empty_flag),
    .active_low (r.ctrl.flag_pol[0]),
    .asserted   (empty_as),
    .rise       (empty_rise)
  );

  aodi_flag_in u_half (
    .clk        (clk),
    .reset      (reset),
    .raw        (fifo_half_full_flag),
    .active_low (r.ctrl.flag_pol[1]),
    .asserted   (half_as),
    .rise       ()
  );

  aodi_flag_in u_full (
    .clk        (clk),
    .reset      (reset),
    .raw        (fifo_full_flag),
    .active_low (r.ctrl.flag_pol[2]),
    .asserted   (full_as),
    .rise       ()
  );

  aodi_pulse #(.W(PWW)) u_timed (
    .clk    (clk),
    .reset  (reset),
    .tick   (output_timebase),
    .start  (timed_start),
    .width  (r.ctrl.pulse_width),
    .active (timed_act),
    .done   (timed_done)
  );

  aodi_pulse #(.W(PWW)) u_host (
    .clk    (clk),
    .reset  (reset),
    .tick   (output_timebase),
    .start  (host_start),
    .width  (r.ctrl.pulse_width),
    .active (host_act),
    .done   (host_done)
  );

  // ----------------------------------------------------------------------
  // Write arbitration
  // ----------------------------------------------------------------------
  assign host_req    = ~host_dac_request_n;
  assign wr_any      = timed_act | host_act;
  // Host is served first when both wait; one write reaches the DACs at a time.
  // The cycle in which a pulse ends still shows served low, so done blocks a repeat start.
  assign host_start  = host_req & ~r.served & ~host_done & ~wr_any
                       & output_timebase;
  assign timed_start = (r.burst != '0) & ~wr_any & ~host_start & output_timebase
                       & ~empty_as;
  assign burst_len   = r.ctrl.multichannel_select ? {1'b0, r.ctrl.channels_m1} + 1'b1
                                                  : (CHW+1)'(1);

  always_comb begin
    case (r.ctrl.refill_condition_select)
      REFILL_ON_EMPTY:        cond = empty_as;
      REFILL_ON_HALF_OR_LESS: cond = ~half_as | empty_as;
      REFILL_ON_NOT_FULL:     cond = ~full_as;
      REFILL_HALF_UNTIL_FULL: cond = r.hyst;
      default:                cond = 1'b0;
    endcase
  end

  assign status = '{reserved_hi: '0, chan_select: r.sel, reserved_lo: '0,
                    data_request: r.data_req, host_busy: host_act,
                    timed_busy: timed_act, flags: {full_as, half_as, empty_as}};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    // Burst and channel counter.
    if (update_event) begin
      next_r.burst = burst_len;
      next_r.chan  = '0;
    end else begin
      if (timed_start) begin
        next_r.burst = r.burst - 1'b1;
      end
      if (timed_done && r.ctrl.multichannel_select) begin
        next_r.chan = r.chan + 1'b1;
      end
    end
    if (host_start) begin
      next_r.sel = host_address;
    end else if (host_act && !host_done) begin
      next_r.sel = r.sel;
    end else begin
      next_r.sel = next_r.chan;
    end
    // Host service: one write per request assertion.
    if (!host_req) begin
      next_r.served = 1'b0;
    end else if (host_done) begin
      next_r.served = 1'b1;
    end
    // Data request while a timed write waits for data.
    if ((r.burst != '0) && !wr_any && output_timebase && empty_as && !host_start) begin
      next_r.data_req = 1'b1;
    end else if (r.data_req && output_timebase && !empty_as) begin
      next_r.data_req = 1'b0;
    end
    // FIFO refill request, interrupt and retransmit.
    if (~half_as | empty_as) begin
      next_r.hyst = 1'b1;
    end else if (full_as) begin
      next_r.hyst = 1'b0;
    end
    next_r.irq    = cond;
    next_r.refill = (r.ctrl.refill_en & cond) ^ r.ctrl.refill_pol;
    next_r.retx_n = ~(empty_rise & r.ctrl.retransmit_enable_bit);
    next_r.tc_out = buffer_count_terminal_in & r.ctrl.tc_out_en;
    // Write channel of the register slave.
    if (axil_req.awvalid && !r.aw_hold && !r.bvalid) begin
      next_r.aw_hold = 1'b1;
      next_r.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && !r.w_hold && !r.bvalid) begin
      next_r.w_hold = 1'b1;
      next_r.w_data = axil_req.wdata;
      next_r.w_strb = axil_req.wstrb;
    end
    if (r.aw_hold && r.w_hold) begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = RESP_OKAY;
      if (r.aw_addr[ADDR_W-1:2] == OFS_CONTROL[ADDR_W-1:2]) begin
        for (int b = 0; b < 4; b++) begin
          if (r.w_strb[b]) begin
            next_r.ctrl[8*b +: 8] = r.w_data[8*b +: 8];
          end
        end
        next_r.ctrl.reserved_hi = '0;
        next_r.ctrl.reserved_lo = 1'b0;
      end else if (r.aw_addr[ADDR_W-1:2] != OFS_STATUS[ADDR_W-1:2]) begin
        next_r.bresp = RESP_SLVERR;
      end
    end else if (r.bvalid && axil_req.bready) begin
      next_r.bvalid = 1'b0;
    end
    // Read channel of the register slave.
    if (axil_req.arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = RESP_OKAY;
      if (axil_req.araddr[ADDR_W-1:2] == OFS_CONTROL[ADDR_W-1:2]) begin
        next_r.rdata = r.ctrl;
      end else if (axil_req.araddr[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2]) begin
        next_r.rdata = status;
      end else begin
        next_r.rdata = '0;
        next_r.rresp = RESP_SLVERR;
      end
    end else if (r.rvalid && axil_req.rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r        <= '0;
      r.ctrl   <= CONTROL_RESET;
      r.refill <= 1'b0;
      r.retx_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign axil_rsp = '{awready: ~r.aw_hold & ~r.bvalid, wready: ~r.w_hold & ~r.bvalid,
                      bvalid: r.bvalid, bresp: r.bresp, arready: ~r.rvalid,
                      rvalid: r.rvalid, rdata: r.rdata, rresp: r.rresp};
  assign host_channel_ready    = ~((host_req & ~r.served) | host_act);
  assign host_dac_write_n      = ~host_act;
  assign timed_dac_write_n     = ~timed_act;
  assign dac_channel_select    = r.sel;
  assign timed_data_request    = r.data_req;
  assign fifo_retransmit_n     = r.retx_n;
  assign fifo_refill_request   = r.refill;
  assign fifo_interrupt        = r.irq;
  assign buffer_count_terminal = r.tc_out;

  always_comb begin
    if (r.ctrl.dual_dac) begin
      dac_write_strobe_n = {1'b1, ~wr_any};
    end else begin
      dac_write_strobe_n = {~(wr_any & r.sel[0]), ~(wr_any & ~r.sel[0])};
    end
    for (int i = 0; i < 2; i++) begin
      if (r.ctrl.load_immediate[i]) begin
        dac_load_strobe_n[i] = ~(timed_dac_write_n & host_dac_write_n);
      end else begin
        dac_load_strobe_n[i] = r.ctrl.load_src_secondary[i] ? ~secondary_update
                                                             : ~primary_update;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_SEL_HOST: assert property (
      $rose(host_act) |-> dac_channel_select == $past(host_address))
    else $error("channel select does not show host address");
  AST_EMPTY_HOLD: assert property (empty_as |=> !$rose(timed_act))
    else $error("timed write started while FIFO empty");
  AST_RETX: assert property (
      $rose(empty_as) && r.ctrl.retransmit_enable_bit |=> !fifo_retransmit_n)
    else $error("retransmit pulse missing");
  AST_READY_DROP: assert property (
      $fell(host_dac_request_n) && !host_act |-> !host_channel_ready)
    else $error("host channel ready not dropped");
  AST_READY_BUSY: assert property (host_act |-> !host_channel_ready)
    else $error("host channel ready during host write");
  AST_ONE_PULSE: assert property ($fell(host_act) ##1 !host_dac_request_n |-> !host_act)
    else $error("second host pulse for one request");
  AST_SPLIT: assert property (
      !r.ctrl.dual_dac && wr_any |-> dac_write_strobe_n[0] != dac_write_strobe_n[1])
    else $error("single mode strobes not exclusive");
  AST_DUAL: assert property (
      r.ctrl.dual_dac |-> dac_write_strobe_n[1] && (dac_write_strobe_n[0] == !wr_any))
    else $error("dual mode strobes wrong");
  AST_CHAN_ZERO: assert property (
      update_event && !host_act && !host_start |=> dac_channel_select == '0)
    else $error("channel select not cleared at update");
  AST_DREQ_HOLD: assert property (timed_data_request && empty_as |=> timed_data_request)
    else $error("data request released while empty");

  COV_HOST: cover property ($fell(host_act) ##[1:20] host_channel_ready);
  COV_MULTI: cover property (timed_done && r.ctrl.multichannel_select ##[1:200] timed_done);
  COV_BLOCKED: cover property ($rose(timed_data_request) ##[1:200] $fell(timed_data_request));
endmodule

// File: bench/aodi_fifo_model.sv
/*
  Output data FIFO model on the far side: holds a fill level of eight words
  and shows active-low empty, half-full and full flags.
  Assumes one word leaves on each falling edge of the timed write.
*/
`timescale 1ns/10ps
module aodi_fifo_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Device side
  input  wire logic write_n,
  input  wire logic retransmit_n,
  input  wire logic refill,
  // Bench control
  input  wire logic stall,
  input  wire logic dump,
  // Flags
  output logic      empty_n,
  output logic      half_n,
  output logic      full_n
);
  logic [3:0] level;
  logic       wprev;

  // A retransmit replays the whole buffer, so the level returns to full.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      level <= 4'h8;
      wprev <= 1'b1;
    end else begin
      wprev <= write_n;
      if (dump)
        level <= 4'h0;
      else if (!retransmit_n)
        level <= 4'h8;
      else if (wprev && !write_n && level != 4'h0)
        level <= level - 4'h1;
      else if (refill && !stall && level != 4'h8)
        level <= level + 4'h1;
    end
  end

  assign empty_n = (level != 4'h0);
  assign half_n  = (level < 4'h4);
  assign full_n  = (level != 4'h8);
endmodule

// File: bench/testbench.sv
/*
  Self-checking bench of the DAC interface core: register bus, timed bursts,
  empty FIFO, retransmit and host writes. Assumes the FIFO model beside it.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import aodi_pkg::*;
  logic clk = 1'b0, reset = 1'b1;
  aodi_axil_req_s req;
  aodi_axil_rsp_s rsp;
  logic output_timebase, update_event, primary_update, secondary_update, bct_in, bct_d;
  logic fe, fh, ff, stall, dump, retx_n, refill, irq, tdr, bct, hready, hw_n, tw_n, host_n;
  logic tw_d = 1'b1, hw_d = 1'b1, rt_d = 1'b1, mode_dual = 1'b0, mode_imm = 1'b0;
  logic [3:0] haddr, sel, a;
  logic [1:0] wstr, ldst, tcnt, r;
  logic [31:0] rv, d;
  logic [3:0] q[$], hq[$];
  int seed = 32'h0b7cba71, bad_count = 0, n_checks = 0, rt = 0, i, j;

  aodi_core u_aodi_core (.clk(clk), .reset(reset), .axil_req(req), .axil_rsp(rsp),
    .output_timebase(output_timebase), .update_event(update_event),
    .primary_update(primary_update), .secondary_update(secondary_update),
    .buffer_count_terminal_in(bct_in), .fifo_empty_flag(fe), .fifo_half_full_flag(fh),
    .fifo_full_flag(ff), .fifo_retransmit_n(retx_n), .fifo_refill_request(refill),
    .fifo_interrupt(irq), .timed_data_request(tdr), .buffer_count_terminal(bct),
    .host_dac_request_n(host_n), .host_address(haddr), .host_channel_ready(hready),
    .host_dac_write_n(hw_n), .dac_channel_select(sel), .timed_dac_write_n(tw_n),
    .dac_write_strobe_n(wstr), .dac_load_strobe_n(ldst));
  aodi_fifo_model u_aodi_fifo_model (.clk(clk), .reset(reset), .write_n(tw_n),
    .retransmit_n(retx_n), .refill(refill), .stall(stall), .dump(dump),
    .empty_n(fe), .half_n(fh), .full_n(ff));

  // ----------------------------------------------------------------------
  // Clock, timebase and random inputs
  // ----------------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    rv = $random(seed);
    tcnt <= tcnt + 2'h1;
    output_timebase <= (tcnt == 2'h3);
    primary_update <= rv[0];
    secondary_update <= rv[1];
    bct_in <= rv[2];
    bct_d <= bct_in;
  end

  // ----------------------------------------------------------------------
  // Pin monitor
  // ----------------------------------------------------------------------
  always @(negedge clk) begin
    if (!reset) begin
      if (tw_n === 1'b0 && tw_d) q.push_back(sel);
      if (hw_n === 1'b0 && hw_d) hq.push_back(sel);
      if (retx_n === 1'b0 && rt_d) rt++;
      if (tw_n === 1'b0 || hw_n === 1'b0) begin
        `CHK("write strobe", ((!mode_dual && sel[0]) ? 2'b01 : 2'b10), wstr)
        if (mode_imm) `CHK("load strobe", 2'b11, ldst)
      end
      if (hw_n === 1'b0) `CHK("ready in write", 1'b0, hready)
    end
    tw_d = tw_n;
    hw_d = hw_n;
    rt_d = retx_n;
  end

  // ----------------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task tmo;
    bad_count++;
    $display("ERROR wait expected done seen timeout");
    close_out;
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt);
    int k;
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    req.awaddr <= ad; req.wdata <= dt; req.wstrb <= 4'hF;
    req.awvalid <= 1'b1; req.wvalid <= 1'b1; req.bready <= 1'b1;
    for (k = 0; k < 64 && !(aw && w); k++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) begin aw = 1'b1; req.awvalid <= 1'b0; end
      if (req.wvalid && rsp.wready) begin w = 1'b1; req.wvalid <= 1'b0; end
    end
    for (k = 0; k < 64 && rsp.bvalid !== 1'b1; k++) @(posedge clk);
    if (k == 64) tmo;
    `CHK("write resp", RESP_OKAY, rsp.bresp)
    req.bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int k;
    @(posedge clk);
    req.araddr <= ad; req.arvalid <= 1'b1; req.rready <= 1'b1;
    for (k = 0; k < 64 && rsp.rvalid !== 1'b1; k++) begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    if (k == 64) tmo;
    dt = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input logic mu, du, input logic [1:0] im, sr,
                                      input logic rx, input logic [3:0] ch, pw);
    ctl = {8'h00, pw, ch, 1'b0, 3'b111, 1'b1, 1'b0, 1'b1, 2'h2, rx, sr, im, du, mu};
  endfunction
  task automatic cfg(input logic [31:0] v);
    axw(OFS_CONTROL, v);
    mode_dual = v[1];
    mode_imm = (v[3:2] != 2'h0);
  endtask
  task automatic kick(input logic u, input logic dm);
    @(posedge clk);
    update_event <= u; dump <= dm;
    @(posedge clk);
    update_event <= 1'b0; dump <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    req = '0; update_event = 1'b0; stall = 1'b0; dump = 1'b0; host_n = 1'b1;
    haddr = 4'h0; tcnt = 2'h0; output_timebase = 1'b0; primary_update = 1'b0;
    secondary_update = 1'b0; bct_in = 1'b0; bct_d = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    axr(OFS_CONTROL, d, r); `CHK("control reset", CONTROL_RESET, d)
    axr(OFS_STATUS, d, r); `CHK("status flags", 3'b110, d[2:0])
    axr(8'h08, d, r); `CHK("unmapped resp", RESP_SLVERR, r)
    `CHK("terminal gated", 1'b0, bct)
    $display("test reset done");
    cfg(ctl(1'b0, 1'b0, 2'h0, 2'h2, 1'b0, 4'h0, 4'h0));
    repeat (8) begin
      @(negedge clk);
      `CHK("load timed", ~{secondary_update, primary_update}, ldst)
      `CHK("terminal", bct_d, bct)
    end
    $display("test timed load done");
    for (j = 0; j < 2; j++) begin
      d = $random(seed);
      cfg(ctl(1'b1, 1'b0, 2'h3, 2'h0, 1'b0, 4'h3, {2'h0, d[1:0]}));
      q.delete();
      kick(1'b1, 1'b0);
      for (i = 0; i < 400 && q.size() < 4; i++) @(posedge clk);
      repeat (40) @(posedge clk);
      `CHK("burst count", 4, q.size())
      for (i = 0; i < q.size(); i++) `CHK("channel", i[3:0], q[i])
    end
    $display("test burst done");
    q.delete();
    stall <= 1'b1;
    kick(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    kick(1'b1, 1'b0);
    repeat (40) @(negedge clk);
    `CHK("held writes", 0, q.size())
    `CHK("data request", 1'b1, tdr)
    `CHK("refill on", 1'b1, refill)
    `CHK("interrupt", 1'b1, irq)
    @(posedge clk);
    stall <= 1'b0;
    for (i = 0; i < 600 && q.size() < 4; i++) @(posedge clk);
    if (i == 600) tmo;
    repeat (8) @(negedge clk);
    `CHK("data request off", 1'b0, tdr)
    `CHK("refill off", 1'b0, refill)
    $display("test empty done");
    cfg(ctl(1'b0, 1'b0, 2'h0, 2'h0, 1'b1, 4'h0, 4'h0));
    rt = 0;
    kick(1'b0, 1'b1);
    repeat (20) @(posedge clk);
    `CHK("retransmit pulses", 1, rt)
    $display("test retransmit done");
    cfg(ctl(1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 4'h0, 4'h0) ^ 32'h0000_0580);
    repeat (4) @(negedge clk);
    `CHK("refill inverted", 1'b1, refill)
    `CHK("interrupt off", 1'b0, irq)
    cfg(ctl(1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 4'h0, 4'h0) ^ 32'h0000_1580);
    repeat (4) @(negedge clk);
    `CHK("refill polarity", 1'b0, refill)
    `CHK("interrupt on", 1'b1, irq)
    axr(OFS_STATUS, d, r); `CHK("flag polarity", 3'b111, d[2:0])
    $display("test polarity done");
    for (j = 0; j < 4; j++) begin
      d = $random(seed);
      cfg(ctl(1'b0, j[0], 2'h0, 2'h0, 1'b0, 4'h0, {2'h0, d[5:4]}));
      hq.delete();
      a = d[3:0];
      @(posedge clk);
      host_n <= 1'b0;
      haddr <= a;
      @(negedge clk);
      `CHK("ready drop", 1'b0, hready)
      for (i = 0; i < 200 && hready !== 1'b1; i++) @(negedge clk);
      if (i == 200) tmo;
      `CHK("host select", a, hq[0])
      @(posedge clk);
      host_n <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("host pulses", 1, hq.size())
    end
    $display("test host done");
    close_out;
  end
endmodule
